// File: rtl/bmdt_pkg.sv
// constants and types of the buffer manager drop counter and discard table registers
// Behaviour
// - count port-two packet drops, at most one per cycle
// - 32-bit counter, resets zero, clears on read
// - counter sticks at all ones, never wraps
// - ready flag zero after reset, self-sets, read-only
// - table init reruns after every fabric reset
// - command write itself starts the table access
// - direction bit four: one reads, zero writes
// - four-bit index picks one of sixteen entries
// - index ranges 8, 16, 32 buffers wide
// - read command loads entry into read-data register
// - entry is 10-bit probability in 1/1024 units
// - yellow packets dropped with looked-up probability
// - table contents undefined after reset
// - read-data register read-only, last read entry
// - buffer usage counted in 128-byte buffers
package bmdt_pkg;

    // register numbers, as used on the register port
    localparam logic [15:0] BMDT_ADDR_DROP_CNT   = 16'h1C07;
    localparam logic [15:0] BMDT_ADDR_INIT_STS   = 16'h1C08;
    localparam logic [15:0] BMDT_ADDR_TBL_CMD    = 16'h1C09;
    localparam logic [15:0] BMDT_ADDR_TBL_WDATA  = 16'h1C0A;
    localparam logic [15:0] BMDT_ADDR_TBL_RDATA  = 16'h1C0B;

    // field positions, widths and table depth
    localparam int          BMDT_CMD_DIR_BIT     = 4;
    localparam int          BMDT_STS_READY_BIT   = 0;
    localparam int          BMDT_PROB_W          = 10;
    localparam int          BMDT_IDX_W           = 4;
    localparam int          BMDT_ENTRIES         = 16;

    // reset values and drop counter ceiling
    localparam logic [31:0] BMDT_DROP_CNT_RST    = 32'h0000_0000;
    localparam logic [31:0] BMDT_DROP_CNT_MAX    = 32'hFFFF_FFFF;
    localparam logic [9:0]  BMDT_WDATA_RST       = 10'h000;
    localparam logic [9:0]  BMDT_RDATA_RST       = 10'h000;

    // buffer usage range boundaries, in 128-byte buffers
    localparam int          BMDT_BUF_BYTES       = 128;
    localparam logic [7:0]  BMDT_USAGE_FINE_END  = 8'h40;
    localparam logic [7:0]  BMDT_USAGE_MID_END   = 8'h80;
    localparam logic [3:0]  BMDT_IDX_MID_BASE    = 4'h8;
    localparam logic [3:0]  BMDT_IDX_HIGH_BASE   = 4'hC;

    // table initialisation time after fabric reset
    localparam int          BMDT_INIT_CYCLES     = 512;

    // random source seed (16-bit maximal lfsr; taps set in bmdt_regs)
    localparam logic [15:0] BMDT_LFSR_SEED       = 16'hACE1;

    // command register contents
    typedef struct packed {
        logic                  dir;    // 1 read, 0 write
        logic [BMDT_IDX_W-1:0] index;  // usage range entry
    } bmdt_cmd_type;

    localparam bmdt_cmd_type BMDT_CMD_RST = '{dir: 1'b0, index: 4'h0};

endpackage

// File: rtl/bmdt_table_mem.sv
// discard probability table storage with one write and two registered read ports
`timescale 1ns/1ps
module bmdt_table_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic             i_clk,
    // write port
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // register-side read port
    input  wire logic [AW-1:0]    i_ra_addr,
    output logic      [WIDTH-1:0] o_ra_data,
    // lookup-side read port
    input  wire logic [AW-1:0]    i_rb_addr,
    output logic      [WIDTH-1:0] o_rb_data
);

    // elaboration check: address must reach every entry
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
        $error("bmdt_table_mem: depth does not fit address width");
    end

    // no reset on purpose: contents stay undefined until software writes them
    logic [WIDTH-1:0] mem [DEPTH];

    // write and both reads in one short process; read data always registered
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_ra_data <= mem[i_ra_addr];
        o_rb_data <= mem[i_rb_addr];
    end

endmodule // bmdt_table_mem

// File: rtl/bmdt_regs.sv
// buffer manager drop counter, init status and random discard table register block
`timescale 1ns/1ps
module bmdt_regs #(
    parameter int INIT_CYCLES = bmdt_pkg::BMDT_INIT_CYCLES,
    parameter int USAGE_W     = 8
) (
    // clock and switch fabric reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    // register port
    input  wire logic [15:0]           i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [31:0]           i_reg_wdata,
    output logic                       o_reg_ready,
    output logic      [31:0]           o_reg_rdata,
    output logic                       o_reg_rvalid,
    // drop events of packets entering on port two
    input  wire logic                  i_port2_drop,
    // yellow packet discard decision
    input  wire logic                  i_yellow_req,
    input  wire logic                  i_yellow_port2,
    input  wire logic [USAGE_W-1:0]    i_yellow_usage,
    output logic                       o_yellow_done,
    output logic                       o_yellow_discard,
    // status
    output logic                       o_tables_initialized_flag
);

    localparam int PW = bmdt_pkg::BMDT_PROB_W;
    localparam int IW = bmdt_pkg::BMDT_IDX_W;

    // elaboration checks
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
        $error("bmdt_regs: INIT_CYCLES out of range");
    end
    if (USAGE_W != 8) begin : g_bad_usage
        $error("bmdt_regs: usage index logic serves 8-bit usage only");
    end

    // registers
    logic [31:0]            drop_cnt_q;      // clear-on-read drop counter
    logic [15:0]            init_cnt_q;      // cycles left in table init
    logic                   init_done_q;     // tables initialised flag
    bmdt_pkg::bmdt_cmd_type cmd_q;           // last command written
    logic [PW-1:0]          wdata_q;         // pending table write value
    logic [PW-1:0]          rdata_q;         // entry fetched by last read command
    logic                   rd_pend_q;       // table read in flight
    logic [31:0]            rsp_q;           // registered read answer
    logic                   rsp_vld_q;       // read answer strobe
    logic [15:0]            lfsr_q;          // random source
    logic                   yel_pend_q;      // lookup in flight
    logic                   yel_port2_q;     // lookup belongs to port two
    logic [PW-1:0]          yel_rand_q;      // random draw for that lookup
    logic                   yel_done_q;      // lookup answer strobe
    logic                   yel_disc_q;      // discard verdict, valid with the strobe

    // table read ports
    logic [PW-1:0]          tbl_ra_data;
    logic [PW-1:0]          tbl_rb_data;

    // trade-off: a read command costs one stall cycle instead of a bypass path
    // register access decode; nothing is taken while a table read is in flight
    wire        acc_ok     = ~rd_pend_q;
    wire        wr_ok      = i_reg_wr & acc_ok;
    wire        rd_ok      = i_reg_rd & acc_ok & ~i_reg_wr;
    wire        hit_cnt    = (i_reg_addr == bmdt_pkg::BMDT_ADDR_DROP_CNT);
    wire        hit_sts    = (i_reg_addr == bmdt_pkg::BMDT_ADDR_INIT_STS);
    wire        hit_cmd    = (i_reg_addr == bmdt_pkg::BMDT_ADDR_TBL_CMD);
    wire        hit_wdat   = (i_reg_addr == bmdt_pkg::BMDT_ADDR_TBL_WDATA);
    wire        hit_rdat   = (i_reg_addr == bmdt_pkg::BMDT_ADDR_TBL_RDATA);
    wire        cmd_wr     = wr_ok & hit_cmd;
    wire        cmd_dir    = i_reg_wdata[bmdt_pkg::BMDT_CMD_DIR_BIT];
    wire [IW-1:0] cmd_idx  = i_reg_wdata[IW-1:0];
    // a write command stores the value already loaded into write data
    wire        tbl_we     = cmd_wr & ~cmd_dir;
    wire        tbl_rd     = cmd_wr & cmd_dir;
    wire        cnt_rd     = rd_ok & hit_cnt;

    // the three step sizes keep fine resolution where queues are nearly empty
    // usage in 128-byte buffers to table index: 8, 16 then 32 buffers a step
    wire [7:0]  usage      = i_yellow_usage;
    wire        use_fine   = usage < bmdt_pkg::BMDT_USAGE_FINE_END;
    wire        use_mid    = usage < bmdt_pkg::BMDT_USAGE_MID_END;
    wire [IW-1:0] use_idx  = use_fine ? {1'b0, usage[5:3]} :
                             use_mid  ? (bmdt_pkg::BMDT_IDX_MID_BASE | {2'b00, usage[5:4]}) :
                                        (bmdt_pkg::BMDT_IDX_HIGH_BASE | {2'b00, usage[6:5]});

    // yellow drop decision: random draw in 0..1023 below entry value
    wire        yel_drop   = yel_pend_q & (yel_rand_q < tbl_rb_data);
    // port-two drops, buffer limit, red or random yellow, count; two in one cycle count once
    wire        cnt_inc    = i_port2_drop | (yel_drop & yel_port2_q);
    wire        cnt_full   = (drop_cnt_q == bmdt_pkg::BMDT_DROP_CNT_MAX);
    wire        lfsr_fb    = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

    // read answer mux; reserved bits and unmapped numbers read zero
    wire [31:0] rd_mux     = hit_cnt  ? drop_cnt_q :
                             hit_sts  ? {31'h0000_0000, init_done_q} :
                             hit_cmd  ? {27'h000_0000, cmd_q} :
                             hit_wdat ? {22'h00_0000, wdata_q} :
                             hit_rdat ? {22'h00_0000, rdata_q} :
                                        32'h0000_0000;

    // the table itself
    bmdt_table_mem #(
        .WIDTH (PW),
        .DEPTH (bmdt_pkg::BMDT_ENTRIES),
        .AW    (IW)
    ) u_table (
        .i_clk     (i_clk),
        .i_wr_en   (tbl_we),
        .i_wr_addr (cmd_idx),
        .i_wr_data (wdata_q),
        .i_ra_addr (cmd_idx),
        .o_ra_data (tbl_ra_data),
        .i_rb_addr (use_idx),
        .o_rb_data (tbl_rb_data)
    );

    // a read and an event in one cycle leave a count of one, so no drop is lost
    // drop counter: saturates, clears on read, an event in the read cycle survives
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            drop_cnt_q <= bmdt_pkg::BMDT_DROP_CNT_RST;
        end else if (cnt_rd) begin
            drop_cnt_q <= {31'h0000_0000, cnt_inc};
        end else if (cnt_inc && !cnt_full) begin
            drop_cnt_q <= drop_cnt_q + 32'h0000_0001;
        end
    end

    // the flag only rises; a new fabric reset is the only way back to zero
    // table init sequencer restarts on every fabric reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_cnt_q  <= 16'(INIT_CYCLES);
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            init_cnt_q  <= init_cnt_q - 16'h0001;
            init_done_q <= (init_cnt_q == 16'h0001);
        end
    end

    // command and write-data registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_q   <= bmdt_pkg::BMDT_CMD_RST;
            wdata_q <= bmdt_pkg::BMDT_WDATA_RST;
        end else begin
            if (cmd_wr) begin
                cmd_q <= '{dir: cmd_dir, index: cmd_idx};
            end
            if (wr_ok && hit_wdat) begin
                wdata_q <= i_reg_wdata[PW-1:0];
            end
        end
    end

    // the access port stalls for the one cycle in which rdata_q is still stale
    // table read: memory answers one cycle later, then the result is held
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_pend_q <= 1'b0;
            rdata_q   <= bmdt_pkg::BMDT_RDATA_RST;
        end else begin
            rd_pend_q <= tbl_rd;
            if (rd_pend_q) begin
                rdata_q <= tbl_ra_data;
            end
        end
    end

    // a read that shares its cycle with a write is dropped; only the write is taken
    // the answer holds until the next taken read, so a slow reader still sees it
    // registered read answer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rsp_q     <= 32'h0000_0000;
            rsp_vld_q <= 1'b0;
        end else begin
            rsp_vld_q <= rd_ok;
            if (rd_ok) begin
                rsp_q <= rd_mux;
            end
        end
    end

    // limitation: a 16-bit source repeats after 65535 draws, fine for a weight
    // random source runs every cycle so draws are not tied to request timing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lfsr_q <= bmdt_pkg::BMDT_LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_fb};
        end
    end

    // entry zero never discards; all ones leaves one chance in 1024 to pass
    // yellow lookup pipeline: request, table read, decision one cycle later
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            yel_pend_q  <= 1'b0;
            yel_port2_q <= 1'b0;
            yel_rand_q  <= 10'h000;
            yel_done_q  <= 1'b0;
            yel_disc_q  <= 1'b0;
        end else begin
            yel_pend_q  <= i_yellow_req;
            yel_port2_q <= i_yellow_port2;
            yel_rand_q  <= lfsr_q[PW-1:0];
            yel_done_q  <= yel_pend_q;
            yel_disc_q  <= yel_drop;
        end
    end

    // outputs: ready is combinational, every data output comes from a flop
    assign o_reg_ready               = acc_ok;
    assign o_reg_rdata               = rsp_q;
    assign o_reg_rvalid              = rsp_vld_q;
    assign o_yellow_done             = yel_done_q;
    assign o_yellow_discard          = yel_disc_q;
    assign o_tables_initialized_flag = init_done_q;

endmodule // bmdt_regs

// File: testbench/bmdt_regs_sva.sv
// port-level checks of the discard table register block
`timescale 1ns/1ps
module bmdt_regs_sva #(
    parameter int INIT_CYCLES = 512,
    parameter int USAGE_W     = 8
) (
    // clock, reset and register port
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [31:0] i_reg_wdata,
    input wire logic        o_reg_ready,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    // yellow port and status
    input wire logic        i_yellow_req,
    input wire logic        o_yellow_done,
    input wire logic        o_yellow_discard,
    input wire logic        o_tables_initialized_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // a read wins only when no write shares its cycle
    wire rd_take = i_reg_rd && !i_reg_wr && o_reg_ready;
    wire rd_cmd  = i_reg_wr && o_reg_ready && i_reg_addr == 16'h1C09 && i_reg_wdata[4];
    int  since_q;  // edges since release, capped so it never wraps
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            since_q <= 0;
        else if (since_q < INIT_CYCLES + 8)
            since_q <= since_q + 1;
    end
    property p_rd_answer; rd_take |=> o_reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rv_cause; o_reg_rvalid |-> $past(rd_take); endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
    property p_cmd_stall; rd_cmd |=> !o_reg_ready ##1 o_reg_ready; endproperty
    a_cmd_stall: assert property (p_cmd_stall) else $error("read command stall wrong");
    property p_yel_done; i_yellow_req |-> ##2 o_yellow_done; endproperty
    a_yel_done: assert property (p_yel_done) else $error("yellow answer late");
    property p_yel_pair; o_yellow_discard |-> o_yellow_done; endproperty
    a_yel_pair: assert property (p_yel_pair) else $error("discard without done");
    property p_flag_early; since_q < 2 |-> !o_tables_initialized_flag; endproperty
    a_flag_early: assert property (p_flag_early) else $error("ready flag set too soon");
    property p_flag_late; since_q == INIT_CYCLES + 4 |-> o_tables_initialized_flag; endproperty
    a_flag_late: assert property (p_flag_late) else $error("ready flag never set");
    property p_flag_stay; o_tables_initialized_flag |=> o_tables_initialized_flag; endproperty
    a_flag_stay: assert property (p_flag_stay) else $error("ready flag dropped");
    property p_sts_resv; rd_take && i_reg_addr == 16'h1C08 |=> o_reg_rdata[31:1] == 31'h0;
    endproperty
    a_sts_resv: assert property (p_sts_resv) else $error("status upper bits set");
    property p_rdat_resv; rd_take && i_reg_addr == 16'h1C0B |=> o_reg_rdata[31:10] == 22'h0;
    endproperty
    a_rdat_resv: assert property (p_rdat_resv) else $error("read data upper bits set");
endmodule // bmdt_regs_sva
bind bmdt_regs bmdt_regs_sva #(.INIT_CYCLES(INIT_CYCLES), .USAGE_W(USAGE_W)) u_sva (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_ready(o_reg_ready),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_yellow_req(i_yellow_req),
    .o_yellow_done(o_yellow_done), .o_yellow_discard(o_yellow_discard),
    .o_tables_initialized_flag(o_tables_initialized_flag));

// File: testbench/bmdt_regs_bench.sv
// self-checking bench of the discard table register block
`timescale 1ns/1ps
module bmdt_regs_bench;
    localparam int INIT = 6;  // short init time keeps the run brief
    logic        i_clk, i_reset_n, i_reg_wr, i_reg_rd, i_port2_drop, i_yellow_req, i_yellow_port2;
    logic [15:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata;
    logic [7:0]  i_yellow_usage;
    logic        o_reg_ready, o_reg_rvalid, o_yellow_done, o_yellow_discard, o_flag;
    logic [31:0] rd_q[$];   // expected read answers, oldest first
    logic        yel_q[$];  // expected discard decisions
    logic [9:0]  tbl[16];   // bench copy of written entries
    int          error_cnt = 0;
    int          checks    = 0;
    bmdt_regs #(.INIT_CYCLES(INIT)) DUT (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_ready(o_reg_ready),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_port2_drop(i_port2_drop),
        .i_yellow_req(i_yellow_req), .i_yellow_port2(i_yellow_port2),
        .i_yellow_usage(i_yellow_usage), .o_yellow_done(o_yellow_done),
        .o_yellow_discard(o_yellow_discard), .o_tables_initialized_flag(o_flag));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // results are sampled mid-cycle, where registered outputs have settled
    always @(negedge i_clk) begin
        if (o_reg_rvalid === 1'b1)
            cmp("rdata", rd_q.size() ? rd_q.pop_front() : 'x, o_reg_rdata);
        if (o_yellow_done === 1'b1)
            cmp("discard", yel_q.size() ? yel_q.pop_front() : 'x, o_yellow_discard);
    end
    // hold the request until an edge that sees ready high
    task automatic take();
        logic r;
        for (int n = 0; n < 20; n++) begin
            @(negedge i_clk) r = o_reg_ready;
            @(posedge i_clk);
            if (r === 1'b1)
                return;
        end
        error_cnt++;
        report_and_stop();
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        take();
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] exp);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        take();
        rd_q.push_back(exp);
        i_reg_rd <= 1'b0;
    endtask
    task automatic tw(logic [3:0] i, logic [9:0] v);
        wr(16'h1C0A, {22'($urandom), v});  // upper bits are reserved noise
        wr(16'h1C09, {27'h0, 1'b0, i});
        tbl[i] = v;
    endtask
    task automatic yel(int u, logic p2, logic exp);
        @(posedge i_clk);
        i_yellow_req   <= 1'b1;
        i_yellow_usage <= u[7:0];
        i_yellow_port2 <= p2;
        yel_q.push_back(exp);
        @(posedge i_clk);
        i_yellow_req <= 1'b0;
    endtask
    function automatic int idx_of(int u);
        return u < 64 ? u / 8 : (u < 128 ? 8 + (u - 64) / 16 : 12 + (u - 128) / 32);
    endfunction
    // register values right after a fabric reset, then the self-set flag
    task automatic fresh();
        rd(16'h1C08, 32'h0);
        @(negedge i_clk) cmp("flag", 32'h0, {31'h0, o_flag});
        rd(16'h1C07, 32'h0);
        rd(16'h1C09, 32'h0);
        rd(16'h1C0A, 32'h0);
        rd(16'h1C0B, 32'h0);
        repeat (INIT) @(posedge i_clk);
        rd(16'h1C08, 32'h1);
        wr(16'h1C08, 32'h0);
        rd(16'h1C08, 32'h1);
        @(negedge i_clk) cmp("flag", 32'h1, {31'h0, o_flag});
        $display("test reset values done");
    endtask
    initial begin
        {i_reset_n, i_reg_wr, i_reg_rd, i_port2_drop, i_yellow_req, i_yellow_port2} = '0;
        i_reg_addr     = 16'h0;
        i_reg_wdata    = 32'h0;
        i_yellow_usage = 8'h0;
        void'($urandom(32'h21a8a6f3));
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        fresh();
        // every entry written at random, then read back in reverse order
        for (int i = 0; i < 16; i++)
            tw(i[3:0], 10'($urandom));
        for (int i = 15; i >= 0; i--) begin
            wr(16'h1C09, {27'h0, 1'b1, i[3:0]});
            rd(16'h1C0B, {22'h0, tbl[i]});
        end
        wr(16'h1C0B, 32'h3FF);
        rd(16'h1C0B, {22'h0, tbl[0]});
        rd(16'h1C09, 32'h10);
        rd(16'h1C0A, {22'h0, tbl[15]});
        $display("test table access done");
        // a burst of drops, then a drop in the very cycle of the clearing read
        checks = checks;
        begin
            int n;
            n = $urandom_range(30, 1);
            @(posedge i_clk);
            i_port2_drop <= 1'b1;
            repeat (n) @(posedge i_clk);
            i_port2_drop <= 1'b0;
            rd(16'h1C07, n);
        end
        fork
            rd(16'h1C07, 32'h0);
            begin
                @(posedge i_clk);
                i_port2_drop <= 1'b1;
                @(posedge i_clk);
                i_port2_drop <= 1'b0;
            end
        join
        rd(16'h1C07, 32'h1);
        $display("test drop counter done");
        // one live entry at a time: every usage outside its range must pass
        for (int i = 0; i < 16; i++)
            tw(i[3:0], 10'h0);
        for (int k = 0; k < 16; k++) begin
            tw(k[3:0], 10'h3FF);
            for (int u = 0; u < 256; u++)
                if (idx_of(u) != k)
                    yel(u, 1'($urandom), 1'b0);
                else if (u == 0 || idx_of(u - 1) != k)
                    yel(u, 1'b1, 1'b1);
            tw(k[3:0], 10'h0);
        end
        rd(16'h1C07, 32'd16);
        $display("test random discard done");
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        fresh();
        for (int n = 0; n < 50 && (rd_q.size() || yel_q.size()); n++)
            @(posedge i_clk);
        if (rd_q.size() || yel_q.size())
            error_cnt++;
        report_and_stop();
    end
endmodule // bmdt_regs_bench
